// File: rtl/adc_ctrl_pkg.sv
// Constants shared by the converter sample/convert control block
package adc_ctrl_pkg;

  // ******************************************************************
  // Register map (byte addresses on APB)
  // ******************************************************************
  localparam logic [11:0] CTRL_ONE_ADDR = 12'h000;
  localparam logic [11:0] CHAN_CFG_ADDR = 12'h004;

  // ******************************************************************
  // Field positions of converter_control_one
  // ******************************************************************
  localparam int DONE_BIT = 0;
  localparam int SAMPLE_CONTROL_BIT = 1;
  localparam int AUTO_SAMPLE_START_BIT = 2;
  localparam int SIMULTANEOUS_SAMPLE_SELECT_BIT = 3;
  localparam int SRCG_BIT = 4;
  localparam int SRC_LSB = 5;
  localparam int SRC_MSB = 7;

  // Field positions of channel configuration register
  localparam int CHANNEL_COUNT_SELECT_LSB = 0;
  localparam int CHANNEL_COUNT_SELECT_MSB = 1;
  localparam int TWELVE_BIT = 2;

  // ******************************************************************
  // Reset values and codes
  // ******************************************************************
  localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
  localparam logic [2:0] CHAN_CFG_RST = 3'h0;
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_EXTERNAL_INTERRUPT_ZERO = 3'h1;
  localparam logic [2:0] SRC_TMR3 = 3'h2;
  localparam logic [2:0] SRC_PWM_SEV = 3'h3;
  localparam logic [2:0] SRC_TMR5 = 3'h4;
  localparam logic [2:0] SRC_CHARGE_TIME_UNIT = 3'h6;
  localparam logic [2:0] SRC_AUTO = 3'h7;
  localparam logic [1:0] CHANNEL_COUNT_SELECT_ONE = 2'h0;
  localparam logic [1:0] CHANNEL_COUNT_SELECT_TWO = 2'h1;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_MHZ = 100;
  localparam int AUTO_SAMPLE_NS = 100;
  localparam int AUTO_SAMPLE_CYC = (AUTO_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC = 14;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_e;

endpackage : adc_ctrl_pkg

// File: rtl/trig_select.sv
// Trigger source multiplexer for end-of-sampling events
`timescale 1ns/1ps
module trig_select (
  // Selection
  input wire logic src_group_i,
  input wire logic [2:0] src_sel_i,
  // Trigger inputs
  input wire logic [3:0] pattern_trig_i,
  input wire logic [2:0] pwm_gen_trig_i,
  input wire logic pwm_sev_trig_i,
  input wire logic tmr3_trig_i,
  input wire logic tmr5_trig_i,
  input wire logic charge_time_unit_trig_i,
  input wire logic external_interrupt_zero_edge_i,
  input wire logic auto_trig_i,
  // Selected trigger
  output logic trig_o
);
  import adc_ctrl_pkg::*;

  // ******************************************************************
  // Group one: pattern outputs and PWM generator compares
  // ******************************************************************
  logic grp1;
  logic grp0;
  always_comb begin
    unique case (src_sel_i)
      3'h7: grp1 = 1'b0; // Reserved gives no trigger
      3'h6: grp1 = pattern_trig_i[3];
      3'h5: grp1 = pattern_trig_i[2];
      3'h4: grp1 = pattern_trig_i[1];
      3'h3: grp1 = pattern_trig_i[0];
      3'h2: grp1 = pwm_gen_trig_i[2];
      3'h1: grp1 = pwm_gen_trig_i[1];
      3'h0: grp1 = pwm_gen_trig_i[0];
    endcase
  end

  // Group zero: timers, charge unit, pin, internal counter
  always_comb begin
    unique case (src_sel_i)
      SRC_AUTO: grp0 = auto_trig_i;
      SRC_CHARGE_TIME_UNIT: grp0 = charge_time_unit_trig_i;
      SRC_TMR5: grp0 = tmr5_trig_i;
      SRC_PWM_SEV: grp0 = pwm_sev_trig_i;
      SRC_TMR3: grp0 = tmr3_trig_i;
      SRC_EXTERNAL_INTERRUPT_ZERO: grp0 = external_interrupt_zero_edge_i;
      default: grp0 = 1'b0; // Manual and reserved codes
    endcase
  end

  assign trig_o = src_group_i ? grp1 : grp0;

endmodule : trig_select

// File: rtl/adc_sample_convert_control.sv
// Sample/convert sequencing control with APB register access
//
// How it works
// - Group one codes pick pattern outputs 12-15
// - Group one low codes pick PWM generators
// - Group zero: counter, charge unit, Timer5
// - Group zero: special event, Timer3, pin edge
// - Code zero: clearing sample bit converts
// - Simultaneous bit only multi-channel, not 12-bit
// - Simultaneous samples four or two channels
// - Otherwise channels sampled one by one
// - Auto start sets sample bit after conversion
// - Without auto start, software starts sampling
// - Sample bit shows sampling versus holding
// - Other codes: hardware clears sample bit
// - Done set on completion, low otherwise
// - Software clears done, never sets it
// - Done cleared when new conversion starts
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module adc_sample_convert_control #(
  parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYC,
  parameter int AUTO_CYCLES = adc_ctrl_pkg::AUTO_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Trigger sources
  input wire logic [3:0] pattern_trig_i,
  input wire logic [2:0] pwm_gen_trig_i,
  input wire logic pwm_sev_trig_i,
  input wire logic tmr3_trig_i,
  input wire logic tmr5_trig_i,
  input wire logic charge_time_unit_trig_i,
  input wire logic external_interrupt_zero_i,
  // Analog front end
  output logic [3:0] sample_hold_en_o,
  output logic conv_start_o,
  output logic [1:0] conv_chan_o
);
  import adc_ctrl_pkg::*;

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic [2:0] src_sel_r;
  logic src_group_r;
  logic simultaneous_sample_select_r;
  logic auto_start_r;
  logic sample_control_r;
  logic done_r;
  logic [1:0] channel_count_select_r;
  logic twelve_r;
  logic external_interrupt_zero_q_r;
  conv_state_e state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic [31:0] prdata_r;

  // ******************************************************************
  // APB decode
  // ******************************************************************
  wire acc = psel_i & penable_i;
  wire hit_ctrl = paddr_i == CTRL_ONE_ADDR;
  wire hit_chan = paddr_i == CHAN_CFG_ADDR;
  wire mapped = hit_ctrl | hit_chan;
  wire wr_ctrl = acc & pwrite_i & hit_ctrl & pstrb_i[0];
  wire wr_chan = acc & pwrite_i & hit_chan & pstrb_i[0];
  wire wr_sample_control = wr_ctrl & pwdata_i[SAMPLE_CONTROL_BIT];
  wire wr_samp0 = wr_ctrl & ~pwdata_i[SAMPLE_CONTROL_BIT];
  wire wr_done0 = wr_ctrl & ~pwdata_i[DONE_BIT];
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o = prdata_r;

  // Simultaneous bit is forced off in 12-bit mode
  wire simultaneous_sample_select_eff = simultaneous_sample_select_r & ~twelve_r;
  wire multi = channel_count_select_r != CHANNEL_COUNT_SELECT_ONE;
  wire simul = simultaneous_sample_select_eff & multi;
  // A write that changes the bit in the start cycle already shapes the first sample
  wire simultaneous_sample_select_wr = wr_ctrl ? pwdata_i[SIMULTANEOUS_SAMPLE_SELECT_BIT] : simultaneous_sample_select_r;
  wire simul_nxt = simultaneous_sample_select_wr & ~twelve_r & multi;
  // Channels in one sequence: 1, 2 or 4
  wire [1:0] last_chan = (channel_count_select_r == CHANNEL_COUNT_SELECT_ONE) ? 2'h0 : (channel_count_select_r == CHANNEL_COUNT_SELECT_TWO) ? 2'h1 : 2'h3;

  wire [15:0] ctrl_rd = {8'h00, src_sel_r, src_group_r, simultaneous_sample_select_eff, auto_start_r,
                         sample_control_r, done_r};

  // ******************************************************************
  // Triggers
  // ******************************************************************
  wire external_interrupt_zero_edge = external_interrupt_zero_i & ~external_interrupt_zero_q_r; // Rising edge as active transition
  wire auto_trig = (state_r == ST_SAMPLE) && (cnt_r == 16'(AUTO_CYCLES - 1));
  logic sel_trig;

  trig_select u_trig (
    .src_group_i(src_group_r),
    .src_sel_i(src_sel_r),
    .pattern_trig_i(pattern_trig_i),
    .pwm_gen_trig_i(pwm_gen_trig_i),
    .pwm_sev_trig_i(pwm_sev_trig_i),
    .tmr3_trig_i(tmr3_trig_i),
    .tmr5_trig_i(tmr5_trig_i),
    .charge_time_unit_trig_i(charge_time_unit_trig_i),
    .external_interrupt_zero_edge_i(external_interrupt_zero_edge),
    .auto_trig_i(auto_trig),
    .trig_o(sel_trig)
  );

  wire manual = ~src_group_r & (src_sel_r == SRC_MANUAL);
  // A write that selects manual mode and clears the sample bit also ends sampling
  wire manual_wr = wr_ctrl & ~pwdata_i[SRCG_BIT] &
                   (pwdata_i[SRC_MSB:SRC_LSB] == SRC_MANUAL);
  // End of sampling: software clear in manual mode, hardware trigger otherwise
  wire end_sample = (state_r == ST_SAMPLE) &
                    ((manual | manual_wr) ? wr_samp0 : sel_trig);
  wire conv_last = (state_r == ST_CONVERT) && (cnt_r == 16'(CONV_CYCLES - 1));
  // Every sampled channel is converted in turn, in both sampling modes
  wire seq_more = conv_last & (chan_r != last_chan);
  wire conv_end = conv_last & ~seq_more;
  wire start_sample = (state_r == ST_IDLE) &
                      (auto_start_r | wr_sample_control);

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 16'h0001;
    chan_nxt = chan_r;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (start_sample) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (end_sample) begin
          state_nxt = ST_CONVERT;
          cnt_nxt = '0;
          chan_nxt = 2'h0;
        end
      end
      ST_CONVERT: begin
        if (seq_more) begin
          cnt_nxt = '0;
          chan_nxt = chan_r + 2'h1;
        end else if (conv_end) begin
          // Auto start resamples at once after the last conversion
          state_nxt = auto_start_r ? ST_SAMPLE : ST_IDLE;
          cnt_nxt = '0;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      chan_r <= '0;
      external_interrupt_zero_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chan_r <= chan_nxt;
      external_interrupt_zero_q_r <= external_interrupt_zero_i;
    end
  end

  // Sample bit tracks sampling; hardware set on auto start
  wire sample_control_nxt = (state_nxt == ST_SAMPLE);

  // Done: set on completion wins; cleared at new conversion start
  // Software may only clear; a written one is ignored
  wire done_nxt = conv_end ? 1'b1 : (end_sample | wr_done0) ? 1'b0 : done_r;

  // Control register fields
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {src_sel_r, src_group_r, simultaneous_sample_select_r, auto_start_r} <= CTRL_ONE_RST[SRC_MSB:AUTO_SAMPLE_START_BIT];
      sample_control_r <= CTRL_ONE_RST[SAMPLE_CONTROL_BIT];
      done_r <= CTRL_ONE_RST[DONE_BIT];
      {twelve_r, channel_count_select_r} <= CHAN_CFG_RST;
    end else begin
      if (wr_ctrl) begin
        src_sel_r <= pwdata_i[SRC_MSB:SRC_LSB];
        src_group_r <= pwdata_i[SRCG_BIT];
        simultaneous_sample_select_r <= pwdata_i[SIMULTANEOUS_SAMPLE_SELECT_BIT];
        auto_start_r <= pwdata_i[AUTO_SAMPLE_START_BIT];
      end
      if (wr_chan) begin
        channel_count_select_r <= pwdata_i[CHANNEL_COUNT_SELECT_MSB:CHANNEL_COUNT_SELECT_LSB];
        twelve_r <= pwdata_i[TWELVE_BIT];
      end
      sample_control_r <= sample_control_nxt;
      done_r <= done_nxt;
    end
  end

  // Read data registered at the setup phase
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_r <= '0;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_r <= hit_ctrl ? {16'h0000, ctrl_rd} :
                  hit_chan ? {29'h0, twelve_r, channel_count_select_r} : 32'h0000_0000;
    end
  end

  // ******************************************************************
  // Front-end drive
  // ******************************************************************
  logic [3:0] sh_nxt;
  always_comb begin
    sh_nxt = 4'h0;
    if (state_nxt == ST_SAMPLE) begin
      if (simul_nxt) begin
        sh_nxt = (channel_count_select_r == CHANNEL_COUNT_SELECT_TWO) ? 4'h3 : 4'hf;
      end else begin
        sh_nxt = 4'h1; // Channel 0 first when sampling in turn
      end
    end else if (state_nxt == ST_CONVERT && ~simul && chan_nxt != last_chan) begin
      // Next channel samples alone while the current one converts
      sh_nxt = 4'h1 << (chan_nxt + 2'h1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_hold_en_o <= 4'h0;
      conv_start_o <= 1'b0;
      conv_chan_o <= 2'h0;
    end else begin
      sample_hold_en_o <= sh_nxt;
      conv_start_o <= end_sample | seq_more; // One pulse per channel conversion
      conv_chan_o <= end_sample ? 2'h0 : seq_more ? chan_r + 2'h1 : conv_chan_o;
    end
  end

endmodule : adc_sample_convert_control

// File: verif/adc_ctrl_sva.sv
// Checker for the sample/convert control block
`timescale 1ns/1ps
module adc_ctrl_sva (
  // Clock, reset and bus
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  // Triggers and front end
  input wire logic [3:0] pattern_trig_i,
  input wire logic tmr3_trig_i,
  input wire logic [3:0] sample_hold_en_o,
  input wire logic conv_start_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] ctl_r;
  logic [2:0] cfg_r;
  wire wr = psel_i & penable_i & pwrite_i & pstrb_i[0];
  wire smp = |sample_hold_en_o;
  // Shadow of the mode fields, so each trigger is judged against its mode
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_r <= 8'h00;
      cfg_r <= 3'h0;
    end else if (wr && paddr_i == 12'h000) begin
      ctl_r <= pwdata_i[7:0];
    end else if (wr && paddr_i == 12'h004) begin
      cfg_r <= pwdata_i[2:0];
    end
  end
  // ******************************************************************
  // Sequencing properties
  // ******************************************************************
  sample_control_start_a: assert property (wr && paddr_i == 12'h000 && pwdata_i[2:1] == 2'b01 && !smp
    |-> ##[1:2] smp) else $error("sampling did not start");
  manual_conv_a: assert property (wr && paddr_i == 12'h000 && pwdata_i[7:4] == 4'h0
    && !pwdata_i[1] && smp |-> ##[1:3] conv_start_o) else $error("no manual conversion");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o) else $error("long start");
  sim_four_a: assert property (smp && ctl_r[3] && cfg_r[1] && !cfg_r[2]
    |-> sample_hold_en_o == 4'hf) else $error("four channels not sampled together");
  sim_two_a: assert property (smp && ctl_r[3] && cfg_r == 3'h1
    |-> sample_hold_en_o == 4'h3) else $error("two channels not sampled together");
  reserved_a: assert property ((ctl_r[7:4] == 4'ha || ctl_r[7:4] == 4'hf) && smp && !wr
    |=> !conv_start_o) else $error("reserved code converted");
  timer3_a: assert property (ctl_r[7:4] == 4'h4 && tmr3_trig_i && smp
    |-> ##[1:3] conv_start_o) else $error("timer trigger ignored");
  pattern15_a: assert property (ctl_r[7:4] == 4'hd && pattern_trig_i[3] && smp
    |-> ##[1:3] conv_start_o) else $error("pattern trigger ignored");
  auto_restart_a: assert property (conv_start_o && ctl_r[2]
    |-> ##[1:64] (smp || !ctl_r[2])) else $error("no automatic resample");
endmodule : adc_ctrl_sva

bind adc_sample_convert_control adc_ctrl_sva i_sva (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pattern_trig_i(pattern_trig_i),
  .tmr3_trig_i(tmr3_trig_i), .sample_hold_en_o(sample_hold_en_o), .conv_start_o(conv_start_o));

// File: verif/trig_source_model.sv
// Behavioural model of the timer, PWM and pattern trigger sources
`timescale 1ns/1ps
module trig_source_model (
  // Clock, reset and command
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic fire_i,
  input wire logic [3:0] which_i,
  input wire logic [2:0] delay_i,
  // Trigger lines
  output logic [3:0] pattern_trig_o,
  output logic [2:0] pwm_gen_trig_o,
  output logic pwm_sev_trig_o,
  output logic tmr3_trig_o,
  output logic tmr5_trig_o,
  output logic charge_time_unit_trig_o,
  output logic ext_int_zero_o
);
  logic [10:0] pulse_r;
  logic [3:0] sel_r;
  logic [2:0] cnt_r;
  logic pend_r;
  // One pulse on the chosen line after a delay, so prompt and slow sources both occur
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_r <= 11'h000;
      sel_r <= 4'h0;
      cnt_r <= 3'h0;
      pend_r <= 1'b0;
      ext_int_zero_o <= 1'b0;
    end else begin
      pulse_r <= 11'h000;
      if (fire_i) begin
        pend_r <= 1'b1;
        sel_r <= which_i;
        cnt_r <= delay_i;
        ext_int_zero_o <= 1'b0; // Pin drops first so every shot is a fresh edge
      end else if (pend_r && cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        if (sel_r == 4'hb) begin
          ext_int_zero_o <= 1'b1;
        end else begin
          pulse_r[sel_r] <= 1'b1;
        end
      end
    end
  end
  assign {charge_time_unit_trig_o, tmr5_trig_o, tmr3_trig_o, pwm_sev_trig_o} = pulse_r[10:7];
  assign {pwm_gen_trig_o, pattern_trig_o} = pulse_r[6:0];
endmodule : trig_source_model

// File: verif/adc_sample_convert_control_bench.sv
// Self-checking bench for the sample/convert control block
`timescale 1ns/1ps
module adc_sample_convert_control_bench;
  import adc_ctrl_pkg::*;
  localparam int SRC0[8] = '{0, 11, 8, 7, 9, 15, 10, 14};
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r, seed = 32'hd2b0d4b6;
  logic [3:0] which = 4'h0, pat, sh;
  logic [2:0] dly = 3'h0, pwmg;
  logic [1:0] cchan;
  logic sev, t3, t5, charge_time_unit, ext0, pready, pslverr, cstart;
  logic [31:0] prdata;
  int mismatches = 0, num_checks = 0, pulses = 0, cycles = 0, k;
  adc_sample_convert_control #(.CONV_CYCLES(8), .AUTO_CYCLES(4)) i_dut (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pattern_trig_i(pat), .pwm_gen_trig_i(pwmg), .pwm_sev_trig_i(sev),
    .tmr3_trig_i(t3), .tmr5_trig_i(t5), .charge_time_unit_trig_i(charge_time_unit), .external_interrupt_zero_i(ext0),
    .sample_hold_en_o(sh), .conv_start_o(cstart), .conv_chan_o(cchan));
  trig_source_model i_src (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .fire_i(fire),
    .which_i(which), .delay_i(dly), .pattern_trig_o(pat), .pwm_gen_trig_o(pwmg),
    .pwm_sev_trig_o(sev), .tmr3_trig_o(t3), .tmr5_trig_o(t5), .charge_time_unit_trig_o(charge_time_unit),
    .ext_int_zero_o(ext0));
  always #5 ref_clk_i = ~ref_clk_i;
  // Count conversions and cut a hung run short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cstart === 1'b1) pulses++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Trigger line expected for a group/code pair: 14 self-timed, 15 none
  function automatic int src_of(input logic [3:0] i);
    if (!i[3]) return SRC0[i[2:0]];
    return (i[2:0] == 3'h7) ? 15 : (i[2:0] > 3'h2) ? int'(i[2:0]) - 3 : int'(i[2:0]) + 4;
  endfunction : src_of
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic poll(input logic x);
    do begin
      apb(1'b0, CTRL_ONE_ADDR, 32'h0);
    end while (r[DONE_BIT] !== x);
    chk(r[DONE_BIT], x);
  endtask : poll
  task automatic shot(input int s);
    seed = xs(seed);
    @(posedge ref_clk_i);
    fire <= 1'b1;
    which <= s[3:0];
    dly <= seed[2:0];
    @(posedge ref_clk_i);
    fire <= 1'b0;
  endtask : shot
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(CTRL_ONE_ADDR, {16'h0, CTRL_ONE_RST});
    rd(12'h008, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, CTRL_ONE_ADDR, 32'h2);
    rd(CTRL_ONE_ADDR, 32'h2);
    chk(sh, 4'h1);
    apb(1'b1, CTRL_ONE_ADDR, 32'h0);
    apb(1'b1, CTRL_ONE_ADDR, 32'h0); // Clearing done mid-conversion is harmless
    poll(1'b1);
    apb(1'b1, CTRL_ONE_ADDR, 32'h0);
    rd(CTRL_ONE_ADDR, 32'h0);
    $display("manual test done");
    // Group/code pairs 1-15, a wrong source first except for the self-timed one, then the selected one
    for (int i = 1; i < 16; i++) begin
      k = src_of(i[3:0]);
      apb(1'b1, CTRL_ONE_ADDR, {24'h0, i[2:0], i[3], 4'h2});
      if (k != 14) begin
        shot((k + 1 + int'(seed[3:0] % 10)) % 12);
        repeat (12) @(posedge ref_clk_i);
        rd(CTRL_ONE_ADDR, {24'h0, i[2:0], i[3], 4'h2});
      end
      if (k < 12) shot(k);
      if (k == 15) apb(1'b1, CTRL_ONE_ADDR, 32'h0);
      poll(1'b1);
      chk(r, (k == 15) ? 32'h1 : {24'h0, i[2:0], i[3], 4'h1});
      apb(1'b1, CTRL_ONE_ADDR, 32'h0);
    end
    $display("trigger test done");
    // Channel counts, width mode and simultaneous select
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, CHAN_CFG_ADDR, {29'h0, i[2:0]});
      apb(1'b1, CTRL_ONE_ADDR, {28'h0, i[3], 3'h2});
      rd(CTRL_ONE_ADDR, {28'h0, i[3] & !i[2], 3'h2});
      chk(sh, (i[3] && !i[2] && i[1:0] != 2'h0) ? (i[1] ? 4'hf : 4'h3) : 4'h1);
      pulses = 0;
      apb(1'b1, CTRL_ONE_ADDR, 32'h0);
      poll(1'b1);
      chk(pulses, i[1] ? 4 : i[0] + 1);
      chk(cchan, i[1] ? 2'h3 : {1'b0, i[0]});
      apb(1'b1, CTRL_ONE_ADDR, 32'h0);
    end
    $display("channel test done");
    apb(1'b1, CHAN_CFG_ADDR, 32'h0);
    pulses = 0;
    apb(1'b1, CTRL_ONE_ADDR, 32'he6);
    poll(1'b1);
    poll(1'b0);
    poll(1'b1);
    chk(pulses > 1, 1'b1);
    apb(1'b1, CTRL_ONE_ADDR, 32'h0); // Auto start leaves in the same write
    repeat (40) @(posedge ref_clk_i);
    apb(1'b1, CTRL_ONE_ADDR, 32'h0);
    rd(CTRL_ONE_ADDR, 32'h0);
    $display("auto test done");
    results();
  end
endmodule : adc_sample_convert_control_bench
